// *** test/riit_periph_model.sv ***
`default_nettype none
module riit_periph_model (
  // From the device
  input wire logic [7:0] a_out,
  input wire logic [7:0] a_oe,
  input wire logic [7:0] b_out,
  input wire logic [7:0] b_oe,
  // External drive, may pull any pin low
  input wire logic [7:0] ext_a,
  input wire logic [7:0] ext_b,
  // Resolved pin levels
  output logic [7:0] a_pin,
  output logic [7:0] b_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Undriven pins float high; a heavy load beats a driven one, so pin and register differ
  assign a_pin = (a_oe & a_out | ~a_oe) & ext_a;
  assign b_pin = (b_oe & b_out | ~b_oe) & ext_b;
endmodule
`default_nettype wire

// *** test/riit_top_assertions.sv ***
`default_nettype none
module riit_checker (
  // Clock and resets
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic chip_reset_n,
  // Processor bus
  input wire logic phase_two_clk,
  input wire riit_pkg::riit_bus_s bus_req,
  input wire logic [7:0] bus_data_lines_in,
  input wire logic [7:0] bus_data_lines_out,
  input wire logic bus_data_lines_oe,
  // Interrupt and port pins
  input wire logic interrupt_request_n_out,
  input wire logic interrupt_request_n_oe,
  input wire logic [7:0] first_port_pins_in,
  input wire logic [7:0] first_port_pins_oe,
  input wire logic [7:0] second_port_pins_out,
  input wire logic [7:0] second_port_pins_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic p2_q;
  logic sel_io;
  logic wr_end;
  logic rd_io;
  logic [2:0] lo3;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Last phase-two level, so its fall marks the end of a bus cycle
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      p2_q <= 1'b0;
    else
      p2_q <= phase_two_clk;
  end
  // Register space selected; read data is trusted only once the request settled
  assign sel_io = bus_req.chip_select_hi & ~bus_req.chip_select_lo_n & bus_req.ram_select_n
                  & chip_reset_n;
  assign wr_end = sel_io & p2_q & ~phase_two_clk & ~bus_req.read_not_write;
  assign rd_io = sel_io & bus_data_lines_oe;
  assign lo3 = bus_req.byte_select_lines[2:0];
  dir_a_store_a: assert property (
    wr_end && lo3 == 3'h1 |=> first_port_pins_oe == $past(bus_data_lines_in))
    else $error("port A direction not stored");
  out_b_store_a: assert property (
    wr_end && lo3 == 3'h2 |=> second_port_pins_out == $past(bus_data_lines_in))
    else $error("port B output not stored");
  pins_a_read_a: assert property (
    rd_io && lo3 == 3'h0 && $stable(bus_req) |-> bus_data_lines_out == $past(first_port_pins_in))
    else $error("port A read is not the pin level");
  reg_b_read_a: assert property (
    rd_io && lo3 == 3'h2 && $stable(bus_req)
    |-> (bus_data_lines_out & second_port_pins_oe) == (second_port_pins_out & second_port_pins_oe))
    else $error("port B read is not the output register");
  flag_spare_zero_a: assert property (
    rd_io && lo3[2] && lo3[0] && $stable(bus_req) |-> bus_data_lines_out[5:0] == 6'h00)
    else $error("flag read spare bits not zero");
  data_oe_read_a: assert property (
    bus_data_lines_oe |-> phase_two_clk && bus_req.read_not_write && bus_req.chip_select_hi
    && !bus_req.chip_select_lo_n && chip_reset_n)
    else $error("data lines driven outside a selected read");
  irq_open_drain_a: assert property (
    interrupt_request_n_oe |-> !interrupt_request_n_out)
    else $error("interrupt pin driven high");
  reset_quiet_a: assert property (
    !chip_reset_n && !$past(chip_reset_n) |-> !interrupt_request_n_oe && !bus_data_lines_oe
    && (first_port_pins_oe | second_port_pins_oe | second_port_pins_out) == 8'h00)
    else $error("outputs active during chip reset");
  // Main scenarios reached
  cover property (wr_end && lo3 == 3'h1);
  cover property (interrupt_request_n_oe);
  cover property (rd_io && lo3[2] && lo3[0]);
endmodule
bind riit_top riit_checker u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .chip_reset_n(chip_reset_n),
  .phase_two_clk(phase_two_clk), .bus_req(bus_req), .bus_data_lines_in(bus_data_lines_in),
  .bus_data_lines_out(bus_data_lines_out), .bus_data_lines_oe(bus_data_lines_oe),
  .interrupt_request_n_out(interrupt_request_n_out),
  .interrupt_request_n_oe(interrupt_request_n_oe), .first_port_pins_in(first_port_pins_in),
  .first_port_pins_oe(first_port_pins_oe), .second_port_pins_out(second_port_pins_out),
  .second_port_pins_oe(second_port_pins_oe)
);
`default_nettype wire

// *** test/test_ram_io_interval_timer.sv ***
`default_nettype none
module test_ram_io_interval_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic chip_reset_n = 1'b1;
  logic phase_two_clk = 1'b0;
  riit_pkg::riit_bus_s bus_req = 11'h380;
  logic [7:0] wdata = 8'h00;
  logic [7:0] ext_a = 8'hff;
  logic [7:0] ext_b = 8'hff;
  logic [7:0] rd_out, a_out, a_oe, b_out, b_oe, a_in, b_in, q;
  logic rd_oe, irq_oe, irq_seen;
  int fails = 0;
  int samples_checked = 0;
  int regs [4];
  int ram_m [128];
  int aq [$];
  int p, e, x;
  // Free-running core clock
  always #25 core_clk = ~core_clk;
  riit_top #(.RAM_WORDS(128)) uut (
    .core_clk(core_clk), .reset_n(reset_n), .chip_reset_n(chip_reset_n),
    .phase_two_clk(phase_two_clk), .bus_req(bus_req), .bus_data_lines_in(wdata),
    .bus_data_lines_out(rd_out), .bus_data_lines_oe(rd_oe), .interrupt_request_n_in(~irq_oe),
    .interrupt_request_n_out(), .interrupt_request_n_oe(irq_oe),
    .first_port_pins_in(a_in), .first_port_pins_out(a_out), .first_port_pins_oe(a_oe),
    .second_port_pins_in(b_in), .second_port_pins_out(b_out), .second_port_pins_oe(b_oe)
  );
  riit_periph_model u_far (
    .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
    .ext_a(ext_a), .ext_b(ext_b), .a_pin(a_in), .b_pin(b_in)
  );
  // Compare and tally
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One phase-two cycle; request held until after the cycle-end edge
  task automatic bus(input logic cs, input logic rnw, input logic rs_n, input logic [6:0] a,
                     input logic [7:0] d);
    @(negedge core_clk);
    bus_req = {cs, ~cs, rs_n, rnw, a};
    wdata = d;
    phase_two_clk = 1'b1;
    repeat (3) @(negedge core_clk);
    q = rd_out;
    irq_seen = irq_oe;
    if (cs && rnw)
      check("data_oe", {7'h00, rd_oe}, 8'h01);
    phase_two_clk = 1'b0;
    @(negedge core_clk);
    bus_req = 11'h380;
  endtask
  // Timer value e cycle ends after loading 2 with p cycles per interval
  function automatic int tval(input int p, input int e);
    int dd;
    dd = (e <= 2 * p + 1) ? 1 + (e - 1) / p : e - 2 * p + 2;
    return (2 - dd) & 255;
  endfunction
  // Watchdog so a hang still reaches the verdict
  initial
  begin
    repeat (60000) @(posedge core_clk);
    fails++;
    finish_test();
  end
  initial
  begin
    x = $urandom(32'h0000_5274);
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    // Park the timer far away, twice in case the first write met a timeout
    repeat (2) bus(1, 0, 1, 7'h17, 8'hff);
    ext_a = 8'h7f;
    bus(1, 1, 1, 7'h05, 8'h00);
    check("edge_dflt", q, 8'h40);
    check("irq_dflt", {7'h00, irq_seen}, 8'h00);
    // Both polarities, enabled
    for (int pol = 0; pol < 2; pol++)
    begin
      ext_a[7] = ~pol[0];
      bus(1, 0, 1, {6'h03, pol[0]}, 8'h00);
      bus(1, 1, 1, 7'h05, 8'h00);
      ext_a[7] = pol[0];
      bus(1, 1, 1, 7'h05, 8'h00);
      check("edge_flag", q, 8'h40);
      check("edge_irq", {7'h00, irq_seen}, 8'h01);
      bus(1, 1, 1, 7'h05, 8'h00);
      check("edge_clr", q, 8'h00);
    end
    // Random port setups against a loaded far side
    for (int i = 0; i < 4; i++)
    begin
      for (int r = 0; r < 4; r++)
      begin
        regs[r] = $urandom % 256;
        bus(1, 0, 1, 7'(r), 8'(regs[r]));
      end
      ext_a = 8'($urandom);
      ext_b = 8'($urandom);
      check("a_oe", a_oe, 8'(regs[1]));
      check("a_out", a_out, 8'(regs[0]));
      check("b_oe", b_oe, 8'(regs[3]));
      check("b_out", b_out, 8'(regs[2]));
      for (int r = 0; r < 4; r++)
      begin
        bus(1, 1, 1, 7'(r), 8'h00);
        x = regs[r];
        if (r == 0)
          x = (regs[0] | ~regs[1]) & ext_a;
        if (r == 2)
          x = (regs[2] & regs[3]) | (~regs[3] & ext_b);
        check("port_rd", q, 8'(x));
      end
    end
    // RAM, with an unselected write between that must not land
    for (int i = 0; i < 8; i++)
    begin
      x = $urandom % 128;
      aq.push_back(x);
      ram_m[x] = $urandom % 256;
      bus(1, 0, 0, 7'(x), 8'(ram_m[x]));
      bus(0, 0, 0, 7'(x), ~8'(ram_m[x]));
    end
    foreach (aq[k])
    begin
      bus(1, 1, 0, 7'(aq[k]), 8'h00);
      check("ram", q, 8'(ram_m[aq[k]]));
    end
    // Chip reset held longer than one phase-two cycle
    chip_reset_n = 1'b0;
    repeat (6) @(negedge core_clk);
    check("rst_pins", a_oe | b_oe | a_out | b_out, 8'h00);
    chip_reset_n = 1'b1;
    bus(1, 1, 1, 7'h01, 8'h00);
    check("rst_dir", q, 8'h00);
    bus(1, 1, 1, 7'h05, 8'h00);
    // Every prescale code; odd codes keep the timer interrupt enabled, even ones do not
    for (int c = 0; c < 4; c++)
    begin
      p = (c == 3) ? 1024 : (1 << (3 * c));
      bus(1, 0, 1, {3'h1, c[0], 1'b1, c[1:0]}, 8'h02);
      for (int k = 1; k <= 2 * p + 4; k++)
      begin
        e = k - 1;
        if (k == p + 1 || k == 2 * p + 1 || k == 2 * p + 4)
        begin
          bus(1, 1, 1, (k > 2 * p + 1) ? 7'h04 : {3'h1, c[0], 3'h4}, 8'h00);
          check("timer", q, 8'(tval(p, e)));
        end
        else
        begin
          bus(1, 1, 1, 7'h05, 8'h00);
          check("flags", q, (e > 2 * p) ? 8'h80 : 8'h00);
        end
        check("irq", {7'h00, irq_seen}, {7'h00, c[0] && e > 2 * p});
      end
      bus(1, 1, 1, 7'h05, 8'h00);
      check("flag_clr", q, 8'h00);
    end
    finish_test();
  end
endmodule
`default_nettype wire

// *** verilog/riit_pkg.sv ***
`default_nettype none
package riit_pkg;
  // Data and address widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int RAM_DEPTH = 128;
  localparam int PRE_W = 10;

  // Address bit positions within the byte select lines
  localparam int BIT_A0 = 0;
  localparam int BIT_A1 = 1;
  localparam int BIT_A2 = 2;
  localparam int BIT_A3 = 3;
  localparam int BIT_A4 = 4;

  // Port register select codes on A1..A0
  localparam logic [1:0] SEL_A_OUT = 2'h0;
  localparam logic [1:0] SEL_A_DIR = 2'h1;
  localparam logic [1:0] SEL_B_OUT = 2'h2;
  localparam logic [1:0] SEL_B_DIR = 2'h3;

  // Prescale shift per A1..A0 code: 1T, 8T, 64T, 1024T
  localparam logic [3:0] PRE_SHIFT_1 = 4'h0;
  localparam logic [3:0] PRE_SHIFT_8 = 4'h3;
  localparam logic [3:0] PRE_SHIFT_64 = 4'h6;
  localparam logic [3:0] PRE_SHIFT_1024 = 4'ha;

  // Flag register field positions
  localparam int FLAG_TIMER_BIT = 7;
  localparam int FLAG_EDGE_BIT = 6;

  // Reset values
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [PRE_W-1:0] PRE_ZERO = 10'h000;

  // Kind of bus access after decode
  typedef enum logic [2:0] {
    ACC_NONE = 3'b000,
    ACC_RAM = 3'b001,
    ACC_PORT = 3'b010,
    ACC_TIMER = 3'b011,
    ACC_FLAGS = 3'b100,
    ACC_EDGE_CTL = 3'b101
  } riit_access_e;

  // One processor bus request as seen by the device
  typedef struct packed {
    logic chip_select_hi;
    logic chip_select_lo_n;
    logic ram_select_n;
    logic read_not_write;
    logic [ADDR_W-1:0] byte_select_lines;
  } riit_bus_s;
endpackage
`default_nettype wire

// *** verilog/riit_top.sv ***
// Summary of operation
// - Chip reset clears both direction and both output registers, making pins inputs.
// - During reset the data bus is not driven and interrupts are disabled.
// - Read/write line high reads, low writes; address selects the target.
// - Interrupt pin is active-low open-drain, from edge flag or timer timeout only.
// - Data lines are driven only during a selected read cycle.
// - Direction bit one makes the pin an output, zero an input.
// - Output pins are driven from the matching output register bit.
// - Port A data read returns the pin levels, not the output register.
// - Port B data read returns the output register for output pins.
// - A 128-byte RAM is addressed by the seven byte select lines.
// - Seven address lines plus RAM select are decoded; two chip selects enable.
// - Timer write address A1..A0 picks 1T, 8T, 64T or 1024T per count.
// - Timer loads the written byte as the number of intervals to count.
// - Counting past zero sets the timeout flag and rolls to all ones.
// - Timeout sets flag bit 7 whether or not the interrupt is enabled.
// - After timeout the counter decrements every clock, reading elapsed time negatively.
// - A3 on any timer access latches the timer interrupt enable.
// - Timer access clears the timer flag, except a read or write in the cycle of the timeout.
// - Timer read before timeout returns whole intervals remaining.
// - Timeout occurs one clock after count times prescale from the write.
// - Selected when high select high and low select low; A2 picks timer.
// - Port access A1..A0: output A, direction A, output B, direction B.
// - Active edge on port A bit 7 sets flag bit 6; flag read clears it.
// - Reset disables edge interrupt, selects falling edge; A4 low write sets both.
`default_nettype none
module riit_top #(
  parameter int RAM_WORDS = riit_pkg::RAM_DEPTH
) (
  // Clock and resets
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic chip_reset_n,
  // Processor bus
  input wire logic phase_two_clk,
  input wire riit_pkg::riit_bus_s bus_req,
  input wire logic [7:0] bus_data_lines_in,
  output logic [7:0] bus_data_lines_out,
  output logic bus_data_lines_oe,
  // Interrupt pin, open drain
  input wire logic interrupt_request_n_in,
  output logic interrupt_request_n_out,
  output logic interrupt_request_n_oe,
  // Port A pins
  input wire logic [7:0] first_port_pins_in,
  output logic [7:0] first_port_pins_out,
  output logic [7:0] first_port_pins_oe,
  // Port B pins
  input wire logic [7:0] second_port_pins_in,
  output logic [7:0] second_port_pins_out,
  output logic [7:0] second_port_pins_oe
);

  // Decode of one access into its target
  function automatic riit_pkg::riit_access_e decode_access(input riit_pkg::riit_bus_s req);
    riit_pkg::riit_access_e kind;
    kind = riit_pkg::ACC_NONE;
    if (req.chip_select_hi && !req.chip_select_lo_n)
    begin
      if (!req.ram_select_n)
      begin
        kind = riit_pkg::ACC_RAM;
      end
      else if (!req.byte_select_lines[riit_pkg::BIT_A2])
      begin
        kind = riit_pkg::ACC_PORT;
      end
      else if (req.read_not_write)
      begin
        // On reads A0 separates timer from flags
        kind = req.byte_select_lines[riit_pkg::BIT_A0] ? riit_pkg::ACC_FLAGS
                                                       : riit_pkg::ACC_TIMER;
      end
      else
      begin
        // On writes A4 separates timer from edge control
        kind = req.byte_select_lines[riit_pkg::BIT_A4] ? riit_pkg::ACC_TIMER
                                                       : riit_pkg::ACC_EDGE_CTL;
      end
    end
    return kind;
  endfunction

  // Prescale shift for an A1..A0 code
  function automatic logic [3:0] prescale_shift(input logic [1:0] code);
    logic [3:0] shift;
    case (code)
      2'h0: shift = riit_pkg::PRE_SHIFT_1;
      2'h1: shift = riit_pkg::PRE_SHIFT_8;
      2'h2: shift = riit_pkg::PRE_SHIFT_64;
      default: shift = riit_pkg::PRE_SHIFT_1024;
    endcase
    return shift;
  endfunction

  riit_pkg::riit_access_e access_kind;
  logic phase_two_prev;
  logic cycle_end;
  logic write_strobe;
  logic read_strobe;
  logic [1:0] reg_sel;
  logic [7:0] port_a_direction;
  logic [7:0] port_b_direction;
  logic [7:0] port_a_output;
  logic [7:0] port_b_output;
  logic [7:0] ram_mem [RAM_WORDS];
  logic [7:0] interval_countdown;
  logic [riit_pkg::PRE_W-1:0] prescale_count;
  logic [3:0] prescale_sel;
  logic timer_expired;
  logic timer_tick;
  logic timeout_event;
  logic timer_flag;
  logic timer_irq_enable;
  logic edge_flag;
  logic edge_irq_enable;
  logic edge_rising;
  logic edge_sense_prev;
  logic edge_event;
  logic [7:0] next_read_data;
  logic [7:0] interrupt_flags;
  logic [7:0] port_b_read;
  logic [riit_pkg::PRE_W-1:0] prescale_reload;

  assign access_kind = decode_access(bus_req);
  assign reg_sel = bus_req.byte_select_lines[riit_pkg::BIT_A1:riit_pkg::BIT_A0];

  // Sampled pins: a fall of phase two closes a bus cycle; bit 7 feeds the edge sense
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase_two_prev <= 1'b0;
      edge_sense_prev <= 1'b0;
    end
    else
    begin
      phase_two_prev <= phase_two_clk;
      edge_sense_prev <= first_port_pins_in[7]; // Sensed whatever the pin direction
    end
  end

  assign cycle_end = phase_two_prev && !phase_two_clk;
  // Accesses are ignored while the chip reset pin is low
  assign write_strobe = cycle_end && chip_reset_n && !bus_req.read_not_write
                        && (access_kind != riit_pkg::ACC_NONE);
  assign read_strobe = cycle_end && chip_reset_n && bus_req.read_not_write
                       && (access_kind != riit_pkg::ACC_NONE);

  // Port registers; chip reset turns every pin into an input
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      port_a_output <= riit_pkg::PORT_RESET;
      port_a_direction <= riit_pkg::PORT_RESET;
      port_b_output <= riit_pkg::PORT_RESET;
      port_b_direction <= riit_pkg::PORT_RESET;
    end
    else if (!chip_reset_n)
    begin
      port_a_output <= riit_pkg::PORT_RESET;
      port_a_direction <= riit_pkg::PORT_RESET;
      port_b_output <= riit_pkg::PORT_RESET;
      port_b_direction <= riit_pkg::PORT_RESET;
    end
    else if (write_strobe && access_kind == riit_pkg::ACC_PORT)
    begin
      case (reg_sel)
        riit_pkg::SEL_A_OUT: port_a_output <= bus_data_lines_in;
        riit_pkg::SEL_A_DIR: port_a_direction <= bus_data_lines_in;
        riit_pkg::SEL_B_OUT: port_b_output <= bus_data_lines_in;
        riit_pkg::SEL_B_DIR: port_b_direction <= bus_data_lines_in;
        default: port_a_output <= port_a_output;
      endcase
    end
  end

  // Pin drivers; an input pin is simply not driven here
  assign first_port_pins_out = port_a_output;
  assign first_port_pins_oe = port_a_direction;
  assign second_port_pins_out = port_b_output;
  assign second_port_pins_oe = port_b_direction;

  // Port B reads the output register where a bit is an output
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < 8; bit_idx++)
    begin : g_port_b_read
      assign port_b_read[bit_idx] = port_b_direction[bit_idx] ? port_b_output[bit_idx]
                                                              : second_port_pins_in[bit_idx];
    end
  endgenerate

  // RAM storage has no reset; contents are undefined until written
  always_ff @(posedge core_clk)
  begin
    if (write_strobe && access_kind == riit_pkg::ACC_RAM)
    begin
      ram_mem[bus_req.byte_select_lines] <= bus_data_lines_in;
    end
  end

  // Interval timer: prescale runs on phase two cycles, T is one cycle
  assign prescale_reload = riit_pkg::PRE_W'((11'h001 << prescale_sel) - 11'h001);
  assign timer_tick = cycle_end && (timer_expired || prescale_count == riit_pkg::PRE_ZERO);
  assign timeout_event = timer_tick && !timer_expired
                         && interval_countdown == riit_pkg::COUNT_RESET;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      interval_countdown <= riit_pkg::COUNT_RESET;
      prescale_count <= riit_pkg::PRE_ZERO;
      prescale_sel <= riit_pkg::PRE_SHIFT_1;
      timer_expired <= 1'b0;
    end
    else if (write_strobe && access_kind == riit_pkg::ACC_TIMER)
    begin
      // The first decrement lands on the next cycle end
      interval_countdown <= bus_data_lines_in;
      prescale_sel <= prescale_shift(reg_sel);
      prescale_count <= riit_pkg::PRE_ZERO;
      timer_expired <= 1'b0;
    end
    else if (cycle_end)
    begin
      if (timer_tick)
      begin
        // Rollover from zero to all ones comes for free
        interval_countdown <= interval_countdown - 8'h01;
        prescale_count <= prescale_reload;
      end
      else
      begin
        prescale_count <= prescale_count - 10'h001;
      end
      if (timeout_event)
      begin
        timer_expired <= 1'b1;
      end
    end
  end

  // Timer flag: a timeout in the access cycle wins over its clear
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      timer_flag <= 1'b0;
    end
    else if (timeout_event)
    begin
      timer_flag <= 1'b1;
    end
    else if ((write_strobe || read_strobe) && access_kind == riit_pkg::ACC_TIMER)
    begin
      timer_flag <= 1'b0;
    end
  end

  // Interrupt enables: A3 of any timer access; edge control ignores the data lines
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      timer_irq_enable <= 1'b0;
      edge_irq_enable <= 1'b0;
      edge_rising <= 1'b0;
    end
    else if (!chip_reset_n)
    begin
      timer_irq_enable <= 1'b0;
      edge_irq_enable <= 1'b0;
      edge_rising <= 1'b0;
    end
    else if ((write_strobe || read_strobe) && access_kind == riit_pkg::ACC_TIMER)
    begin
      timer_irq_enable <= bus_req.byte_select_lines[riit_pkg::BIT_A3];
    end
    else if (write_strobe && access_kind == riit_pkg::ACC_EDGE_CTL)
    begin
      edge_irq_enable <= bus_req.byte_select_lines[riit_pkg::BIT_A1];
      edge_rising <= bus_req.byte_select_lines[riit_pkg::BIT_A0];
    end
  end

  assign edge_event = edge_rising ? (!edge_sense_prev && first_port_pins_in[7])
                                  : (edge_sense_prev && !first_port_pins_in[7]);

  // Edge flag may set during chip reset; a flag read clears it
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      edge_flag <= 1'b0;
    end
    else if (edge_event)
    begin
      edge_flag <= 1'b1;
    end
    else if (read_strobe && access_kind == riit_pkg::ACC_FLAGS)
    begin
      edge_flag <= 1'b0;
    end
  end

  // Flag register view, unused bits zero
  always_comb
  begin
    interrupt_flags = riit_pkg::COUNT_RESET;
    interrupt_flags[riit_pkg::FLAG_TIMER_BIT] = timer_flag;
    interrupt_flags[riit_pkg::FLAG_EDGE_BIT] = edge_flag;
  end

  // Read data multiplexer
  always_comb
  begin
    next_read_data = riit_pkg::COUNT_RESET;
    case (access_kind)
      riit_pkg::ACC_RAM: next_read_data = ram_mem[bus_req.byte_select_lines];
      riit_pkg::ACC_PORT:
      begin
        case (reg_sel)
          riit_pkg::SEL_A_OUT: next_read_data = first_port_pins_in;
          riit_pkg::SEL_A_DIR: next_read_data = port_a_direction;
          riit_pkg::SEL_B_OUT: next_read_data = port_b_read;
          default: next_read_data = port_b_direction;
        endcase
      end
      riit_pkg::ACC_TIMER: next_read_data = interval_countdown;
      riit_pkg::ACC_FLAGS: next_read_data = interrupt_flags;
      default: next_read_data = riit_pkg::COUNT_RESET;
    endcase
  end

  // Read data is registered so the bus sees a clean value
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_data_lines_out <= riit_pkg::COUNT_RESET;
    end
    else
    begin
      bus_data_lines_out <= next_read_data;
    end
  end

  // Drive only in the high phase of a selected read, never in reset
  assign bus_data_lines_oe = chip_reset_n && phase_two_clk && phase_two_prev
                             && bus_req.read_not_write
                             && access_kind != riit_pkg::ACC_NONE;

  // Open drain: output held low, the enable pulls the shared line
  assign interrupt_request_n_out = 1'b0;
  assign interrupt_request_n_oe = (timer_flag && timer_irq_enable)
                                  || (edge_flag && edge_irq_enable);

endmodule
`default_nettype wire
